// file: pkg/hib_params.svh
`ifndef HIB_PARAMS_SVH
`define HIB_PARAMS_SVH

// Register byte offsets.
`define HIB_OFS_COUNTER      8'h00
`define HIB_OFS_MATCH0       8'h04
`define HIB_OFS_MATCH1       8'h08
`define HIB_OFS_LOAD         8'h0c
`define HIB_OFS_CONTROL      8'h10
`define HIB_OFS_IRQ_MASK     8'h14
`define HIB_OFS_IRQ_RAW      8'h18
`define HIB_OFS_IRQ_MASKED   8'h1c
`define HIB_OFS_IRQ_CLEAR    8'h20

// Reset values.
`define HIB_RST_COUNTER      32'h0000_0000
`define HIB_RST_MATCH        32'hffff_ffff
`define HIB_RST_LOAD         32'hffff_ffff
`define HIB_RST_IRQ          4'h0

// Control register bit positions.
`define HIB_CTL_CLOCK_ENABLE 6
`define HIB_CTL_BATT_MON     5
`define HIB_CTL_WAKE_PIN     4
`define HIB_CTL_COUNTER_WAKE 3
`define HIB_CTL_CLOCK_SEL    2
`define HIB_CTL_HIB_REQUEST  1
`define HIB_CTL_COUNTER_EN   0
`define HIB_CTL_WIDTH        7
// Bit 31 of the control register reads as one, as after reset.
`define HIB_CTL_FIXED_ONES   32'h8000_0000

// Interrupt status bit positions.
`define HIB_IRQ_MATCH0       0
`define HIB_IRQ_MATCH1       1
`define HIB_IRQ_LOW_BATTERY  2
`define HIB_IRQ_WAKE_PIN     3
`define HIB_IRQ_WIDTH        4

// Crystal path divide ratio.
`define HIB_DIV_RATIO        128

`endif

// file: pkg/hib_pkg.sv
`default_nettype none

package hib_pkg;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avl_req_t;

  typedef struct packed {
    logic module_clock_enable;
    logic battery_monitor_enable;
    logic wake_pin_enable;
    logic counter_wake_enable;
    logic module_clock_select;
    logic hibernation_request;
    logic counter_enable;
  } control_t;

  typedef enum logic [0:0] {
    st_awake,
    st_hibernating
  } power_state_t;

endpackage

`default_nettype wire

// file: design/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // The first stage feeds only the second stage, never any other logic.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= pin_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign pin_out = sync_q;

endmodule // pin_sync

`default_nettype wire

// file: design/tick_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "hib_params.svh"

module tick_divider #(
  parameter int DIV_RATIO = `HIB_DIV_RATIO
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic osc_level,
  input  wire logic use_raw,
  input  wire logic run,
  output logic      tick
);

  localparam int CW = $clog2(DIV_RATIO);

  logic          osc_prev_q;
  logic          osc_prev_d;
  logic [CW-1:0] div_q;
  logic [CW-1:0] div_d;
  logic          osc_rise;

  // The oscillator is sampled on the system clock, so its rate must stay
  // well below half of clk_sys; faster crystals lose edges here.
  assign osc_rise = osc_level & ~osc_prev_q;

  always_comb begin
    osc_prev_d = osc_level;
    div_d      = div_q;
    tick       = 1'b0;
    if (run && osc_rise) begin
      if (use_raw) begin
        tick = 1'b1;
      end else if (div_q == CW'(DIV_RATIO - 1)) begin
        div_d = '0;
        tick  = 1'b1;
      end else begin
        div_d = div_q + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      osc_prev_q <= 1'b0;
      div_q      <= '0;
    end else begin
      osc_prev_q <= osc_prev_d;
      div_q      <= div_d;
    end
  end

endmodule // tick_divider

`default_nettype wire

// file: design/hibernation_control.sv
// How it works
// - Battery monitor enable gates low-battery detection.
// - Wake pin enable lets pin re-power device.
// - Counter wake enable lets matches re-power device.
// - Clock select: crystal divided 128, or raw.
// - Request bit starts hibernation; wake clears it.
// - Load register write sets counter; counter read-only.
`timescale 1ns/1ps
`default_nettype none
`include "hib_params.svh"

module hibernation_control (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire hib_pkg::avl_req_t avl_req,
  output logic [31:0]            avl_readdata,
  output logic                   avl_waitrequest,
  input  wire logic              osc_in,
  input  wire logic              wake_n_pin,
  input  wire logic              battery_low_pin,
  output logic                   power_cut,
  output logic                   irq
);

  import hib_pkg::*;

  // Synchronised pins.
  logic       osc_sync;
  logic       wake_n_sync;
  logic       batt_low_sync;
  logic [2:0] pins_sync;

  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pin_in  ({battery_low_pin, wake_n_pin, osc_in}),
    .pin_out (pins_sync)
  );

  assign osc_sync      = pins_sync[0];
  assign wake_n_sync   = pins_sync[1];
  assign batt_low_sync = pins_sync[2];

  // Register file state.
  control_t                  ctl_q;
  control_t                  ctl_d;
  logic [31:0]               counter_q;
  logic [31:0]               counter_d;
  logic [31:0]               match0_q;
  logic [31:0]               match0_d;
  logic [31:0]               match1_q;
  logic [31:0]               match1_d;
  logic [31:0]               load_q;
  logic [31:0]               load_d;
  logic [`HIB_IRQ_WIDTH-1:0] irq_mask_q;
  logic [`HIB_IRQ_WIDTH-1:0] irq_mask_d;
  logic [`HIB_IRQ_WIDTH-1:0] irq_raw_q;
  logic [`HIB_IRQ_WIDTH-1:0] irq_raw_d;

  // Bus handshake state.
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Power state.
  power_state_t state_q;
  power_state_t state_d;
  logic         wake_n_prev_q;
  logic         wake_n_prev_d;

  // Event terms.
  logic                      tick;
  logic                      counter_run;
  logic                      pin_event;
  logic                      match0_hit;
  logic                      match1_hit;
  logic                      low_battery;
  logic                      wake_event;
  logic [`HIB_IRQ_WIDTH-1:0] irq_events;
  logic                      wr_take;
  logic                      rd_take;
  logic [31:0]               ctl_word;
  logic [31:0]               wmask;
  logic [31:0]               irq_mask_word;
  logic [31:0]               irq_raw_word;
  logic [31:0]               irq_pend_word;
  logic                      power_cut_d;
  logic                      irq_d;

  // The module clock enable gates every tick, so a stopped module keeps
  // both the divider phase and the counter value.
  assign counter_run = ctl_q.module_clock_enable & ctl_q.counter_enable;

  tick_divider #(
    .DIV_RATIO (`HIB_DIV_RATIO)
  ) u_tick_divider (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .osc_level (osc_sync),
    .use_raw   (ctl_q.module_clock_select),
    .run       (counter_run),
    .tick      (tick)
  );

  // Matches are judged on the tick at which the counter holds the value,
  // so a held counter raises one event per tick, not one per clk_sys.
  assign match0_hit  = tick && (counter_q == match0_q);
  assign match1_hit  = tick && (counter_q == match1_q);
  // The edge register resets low like the synchroniser, so the pin settling
  // to its idle high level after reset is not taken for a wake edge.
  assign pin_event   = wake_n_prev_q & ~wake_n_sync;
  // Low battery is a level: its status bit sets again on every cycle while
  // the condition lasts, so a clear only sticks once the pin has dropped.
  assign low_battery = ctl_q.battery_monitor_enable & batt_low_sync;

  always_comb begin
    irq_events = '0;
    irq_events[`HIB_IRQ_MATCH0]      = match0_hit;
    irq_events[`HIB_IRQ_MATCH1]      = match1_hit;
    irq_events[`HIB_IRQ_LOW_BATTERY] = low_battery;
    irq_events[`HIB_IRQ_WAKE_PIN]    = pin_event;
  end

  always_comb begin
    wake_event = 1'b0;
    if (ctl_q.wake_pin_enable && pin_event) begin
      wake_event = 1'b1;
    end
    if (ctl_q.counter_wake_enable && (match0_hit || match1_hit)) begin
      wake_event = 1'b1;
    end
  end

  // Avalon slave: one wait cycle, then the answer at the next edge.
  assign avl_waitrequest = (avl_req.read | avl_req.write) & ~ack_q;
  assign wr_take         = avl_req.write & ack_q;
  assign rd_take         = avl_req.read & ~ack_q;
  assign avl_readdata    = rdata_q;

  always_comb begin
    ctl_word = `HIB_CTL_FIXED_ONES;
    ctl_word[`HIB_CTL_WIDTH-1:0] = ctl_q;
  end

  // One byte lane of the write mask per byteenable bit.
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign wmask[8*lane +: 8] = {8{avl_req.byteenable[lane]}};
    end
  endgenerate

  // Status words are zero-extended to the bus width.
  always_comb begin
    irq_mask_word = '0;
    irq_raw_word  = '0;
    irq_pend_word = '0;
    irq_mask_word[`HIB_IRQ_WIDTH-1:0] = irq_mask_q;
    irq_raw_word[`HIB_IRQ_WIDTH-1:0]  = irq_raw_q;
    irq_pend_word[`HIB_IRQ_WIDTH-1:0] = irq_raw_q & irq_mask_q;
  end

  always_comb begin
    // Read data are captured at the edge that first sees the request and
    // then stand through the answer cycle, so a tick cannot tear the word.
    ack_d   = (avl_req.read | avl_req.write) & ~ack_q;
    rdata_d = rdata_q;
    if (rd_take) begin
      case (avl_req.address)
        `HIB_OFS_COUNTER:    rdata_d = counter_q;
        `HIB_OFS_MATCH0:     rdata_d = match0_q;
        `HIB_OFS_MATCH1:     rdata_d = match1_q;
        `HIB_OFS_LOAD:       rdata_d = load_q;
        `HIB_OFS_CONTROL:    rdata_d = ctl_word;
        `HIB_OFS_IRQ_MASK:   rdata_d = irq_mask_word;
        `HIB_OFS_IRQ_RAW:    rdata_d = irq_raw_word;
        `HIB_OFS_IRQ_MASKED: rdata_d = irq_pend_word;
        default:             rdata_d = 32'h0;
      endcase
    end
  end

  // Register updates and the counter.
  always_comb begin
    ctl_d      = ctl_q;
    match0_d   = match0_q;
    match1_d   = match1_q;
    load_d     = load_q;
    irq_mask_d = irq_mask_q;
    irq_raw_d  = irq_raw_q;
    counter_d  = counter_q;

    if (tick) begin
      counter_d = counter_q + 32'h1;
    end

    // Hardware drops the request on wake; a write in the same cycle that
    // sets it again is taken as a fresh request.
    if (wake_event) begin
      ctl_d.hibernation_request = 1'b0;
    end

    if (wr_take) begin
      case (avl_req.address)
        `HIB_OFS_MATCH0: begin
          match0_d = (match0_q & ~wmask) | (avl_req.writedata & wmask);
        end
        `HIB_OFS_MATCH1: begin
          match1_d = (match1_q & ~wmask) | (avl_req.writedata & wmask);
        end
        `HIB_OFS_LOAD: begin
          load_d    = (load_q & ~wmask) | (avl_req.writedata & wmask);
          counter_d = load_d;
        end
        `HIB_OFS_CONTROL: begin
          if (avl_req.byteenable[0]) begin
            ctl_d = avl_req.writedata[`HIB_CTL_WIDTH-1:0];
          end
        end
        `HIB_OFS_IRQ_MASK: begin
          if (avl_req.byteenable[0]) begin
            irq_mask_d = avl_req.writedata[`HIB_IRQ_WIDTH-1:0];
          end
        end
        `HIB_OFS_IRQ_CLEAR: begin
          if (avl_req.byteenable[0]) begin
            irq_raw_d = irq_raw_q & ~avl_req.writedata[`HIB_IRQ_WIDTH-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // New events are applied after the clear so that none is lost.
    irq_raw_d = irq_raw_d | irq_events;
  end

  // Power sequencing: cut power while a request stands, restore on wake.
  always_comb begin
    state_d       = state_q;
    wake_n_prev_d = wake_n_sync;
    case (state_q)
      st_awake: begin
        if (ctl_q.hibernation_request && !wake_event) begin
          state_d = st_hibernating;
        end
      end
      st_hibernating: begin
        if (wake_event || !ctl_q.hibernation_request) begin
          state_d = st_awake;
        end
      end
      default: begin
        state_d = st_awake;
      end
    endcase
  end

  // Outputs are registered from next-state values, so each one moves at the
  // same edge as the state it reports.
  always_comb begin
    power_cut_d = (state_d == st_hibernating);
    irq_d       = |(irq_raw_d & irq_mask_d);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q         <= '0;
      counter_q     <= `HIB_RST_COUNTER;
      match0_q      <= `HIB_RST_MATCH;
      match1_q      <= `HIB_RST_MATCH;
      load_q        <= `HIB_RST_LOAD;
      irq_mask_q    <= `HIB_RST_IRQ;
      irq_raw_q     <= `HIB_RST_IRQ;
      ack_q         <= 1'b0;
      rdata_q       <= 32'h0;
      state_q       <= st_awake;
      wake_n_prev_q <= 1'b0;
      power_cut     <= 1'b0;
      irq           <= 1'b0;
    end else begin
      ctl_q         <= ctl_d;
      counter_q     <= counter_d;
      match0_q      <= match0_d;
      match1_q      <= match1_d;
      load_q        <= load_d;
      irq_mask_q    <= irq_mask_d;
      irq_raw_q     <= irq_raw_d;
      ack_q         <= ack_d;
      rdata_q       <= rdata_d;
      state_q       <= state_d;
      wake_n_prev_q <= wake_n_prev_d;
      power_cut     <= power_cut_d;
      irq           <= irq_d;
    end
  end

endmodule // hibernation_control

`default_nettype wire

// file: testbench/hibernation_control_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "hib_params.svh"

module hibernation_control_checker (
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire hib_pkg::avl_req_t avl_req,
  input wire logic [31:0]       avl_readdata,
  input wire logic              avl_waitrequest,
  input wire logic              osc_in,
  input wire logic              wake_n_pin,
  input wire logic              battery_low_pin,
  input wire logic              power_cut,
  input wire logic              irq
);
  import hib_pkg::*;
  // Shadows of the enables, since the checker only sees the bus.
  logic       done;
  logic [6:0] ctl_q, ctl_d;
  logic [3:0] mask_q, mask_d;
  assign done = avl_req.write && !avl_waitrequest && avl_req.byteenable[0];
  always_comb begin
    ctl_d = ctl_q;
    mask_d = mask_q;
    if (done && avl_req.address == `HIB_OFS_CONTROL) begin
      ctl_d = avl_req.writedata[6:0];
    end
    if (done && avl_req.address == `HIB_OFS_IRQ_MASK) begin
      mask_d = avl_req.writedata[3:0];
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= '0;
      mask_q <= '0;
    end else begin
      ctl_q <= ctl_d;
      mask_q <= mask_d;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_wait_one: assert property (
    (avl_req.read || avl_req.write) && avl_waitrequest |=> !avl_waitrequest)
    else $error("second wait cycle");
  chk_wait_first: assert property (
    (avl_req.read || avl_req.write) && !$past(avl_req.read || avl_req.write)
    |-> avl_waitrequest) else $error("no wait on new request");
  chk_wait_idle: assert property (
    !(avl_req.read || avl_req.write) |-> !avl_waitrequest)
    else $error("wait without request");
  chk_rdata_hold: assert property (
    !(avl_req.read && avl_waitrequest) |=> $stable(avl_readdata))
    else $error("read data moved");
  chk_cut_on_req: assert property (
    done && avl_req.address == `HIB_OFS_CONTROL && avl_req.writedata[1]
    |-> ##[1:3] power_cut) else $error("no power cut");
  chk_cut_clear: assert property (
    done && avl_req.address == `HIB_OFS_CONTROL && !avl_req.writedata[1]
    |-> ##[1:3] !power_cut) else $error("power cut stuck");
  chk_wake_pin: assert property (
    power_cut && ctl_q[4] && $fell(wake_n_pin) |-> ##[1:6] !power_cut)
    else $error("pin did not wake");
  chk_cut_hold: assert property (
    power_cut && !ctl_q[4] && !ctl_q[3] && !avl_req.write &&
    !$past(avl_req.write) && !$past(avl_req.write, 2) |=> power_cut)
    else $error("woke while disabled");
  chk_irq_mask: assert property (
    mask_q == 4'h0 |-> !irq) else $error("irq while masked");
  chk_batt_irq: assert property (
    battery_low_pin [*4] ##0 (ctl_q[5] && mask_q[2]) |-> ##[0:2] irq)
    else $error("no low battery irq");
endmodule // hibernation_control_checker

bind hibernation_control hibernation_control_checker u_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .avl_req(avl_req),
  .avl_readdata(avl_readdata), .avl_waitrequest(avl_waitrequest),
  .osc_in(osc_in), .wake_n_pin(wake_n_pin),
  .battery_low_pin(battery_low_pin), .power_cut(power_cut), .irq(irq));

`default_nettype wire

// file: testbench/hibernation_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "hib_params.svh"

module hibernation_control_tb;
  import hib_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  avl_req_t    req = '0;
  logic [31:0] avl_readdata;
  logic        avl_waitrequest;
  logic        osc_in = 1'b0;
  logic        wake_n_pin = 1'b1;
  logic        battery_low_pin = 1'b0;
  logic        power_cut;
  logic        irq;
  int          error_cnt = 0;
  int          samples_checked = 0;
  logic [31:0] seed = 32'h0001_1e02;
  logic [31:0] v;
  logic [31:0] q;

  always #50 clk_sys = ~clk_sys;

  hibernation_control dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .avl_req(req),
    .avl_readdata(avl_readdata), .avl_waitrequest(avl_waitrequest),
    .osc_in(osc_in), .wake_n_pin(wake_n_pin),
    .battery_low_pin(battery_low_pin), .power_cut(power_cut), .irq(irq));

  function automatic logic [31:0] xorshift(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic logic [31:0] ctl_val(logic [6:0] b);
    return `HIB_CTL_FIXED_ONES | {25'h0, b};
  endfunction

  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge.
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    req <= '{read: !wr, write: wr, address: a, writedata: d,
             byteenable: 4'hf};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avl_waitrequest !== 1'b0 && n < 50);
    q = avl_readdata;
    req <= '0;
    chk("answer", 32'(1), 32'(n < 50));
  endtask

  task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  task automatic osc(int n);
    repeat (n) begin
      @(posedge clk_sys) osc_in <= 1'b1;
      repeat (4) @(posedge clk_sys);
      osc_in <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask

  task automatic wake;
    @(posedge clk_sys) wake_n_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wake_n_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdc("ctl_rst", `HIB_OFS_CONTROL, `HIB_CTL_FIXED_ONES);
    rdc("m0_rst", `HIB_OFS_MATCH0, `HIB_RST_MATCH);
    rdc("m1_rst", `HIB_OFS_MATCH1, `HIB_RST_MATCH);
    rdc("ld_rst", `HIB_OFS_LOAD, `HIB_RST_LOAD);
    rdc("cnt_rst", `HIB_OFS_COUNTER, `HIB_RST_COUNTER);
    seed = xorshift(seed);
    v = {1'b0, seed[30:0]};
    bus(1'b1, `HIB_OFS_LOAD, v);
    bus(1'b1, `HIB_OFS_COUNTER, ~v);
    rdc("cnt_ld", `HIB_OFS_COUNTER, v);
    rdc("unmapped", 8'h40, 32'h0);
    $display("test registers done");
    bus(1'b1, `HIB_OFS_CONTROL, 32'h44);
    osc(3);
    rdc("cnt_stop", `HIB_OFS_COUNTER, v);
    bus(1'b1, `HIB_OFS_CONTROL, 32'h45);
    osc(5);
    rdc("cnt_raw", `HIB_OFS_COUNTER, v + 5);
    bus(1'b1, `HIB_OFS_CONTROL, 32'h41);
    osc(`HIB_DIV_RATIO);
    rdc("cnt_div", `HIB_OFS_COUNTER, v + 6);
    $display("test counter done");
    seed = xorshift(seed);
    v = {1'b0, seed[30:0]};
    bus(1'b1, `HIB_OFS_MATCH0, v + 2);
    bus(1'b1, `HIB_OFS_LOAD, v);
    bus(1'b1, `HIB_OFS_IRQ_MASK, 32'h1);
    bus(1'b1, `HIB_OFS_CONTROL, 32'h4f);
    repeat (3) @(posedge clk_sys);
    chk("cut_req", 32'(1), 32'(power_cut));
    osc(2);
    chk("cut_early", 32'(1), 32'(power_cut));
    osc(1);
    chk("cut_match", 32'(0), 32'(power_cut));
    chk("irq_match", 32'(1), 32'(irq));
    rdc("ctl_wake", `HIB_OFS_CONTROL, ctl_val(7'h4d));
    rdc("raw_match", `HIB_OFS_IRQ_RAW, 32'h1);
    bus(1'b1, `HIB_OFS_IRQ_CLEAR, 32'h1);
    @(posedge clk_sys);
    chk("irq_clr", 32'(0), 32'(irq));
    bus(1'b1, `HIB_OFS_MATCH1, v + 4);
    bus(1'b1, `HIB_OFS_IRQ_MASK, 32'h2);
    bus(1'b1, `HIB_OFS_CONTROL, 32'h4f);
    repeat (3) @(posedge clk_sys);
    osc(1);
    chk("cut_m1", 32'(1), 32'(power_cut));
    osc(1);
    chk("wake_m1", 32'(0), 32'(power_cut));
    chk("irq_m1", 32'(1), 32'(irq));
    rdc("raw_m1", `HIB_OFS_IRQ_RAW, 32'h2);
    $display("test match wake done");
    bus(1'b1, `HIB_OFS_CONTROL, 32'h52);
    repeat (3) @(posedge clk_sys);
    chk("cut_pin", 32'(1), 32'(power_cut));
    wake();
    chk("pin_wake", 32'(0), 32'(power_cut));
    rdc("ctl_pin", `HIB_OFS_CONTROL, ctl_val(7'h50));
    bus(1'b1, `HIB_OFS_CONTROL, 32'h42);
    repeat (3) @(posedge clk_sys);
    wake();
    chk("pin_off", 32'(1), 32'(power_cut));
    bus(1'b1, `HIB_OFS_CONTROL, 32'h40);
    repeat (3) @(posedge clk_sys);
    chk("sw_wake", 32'(0), 32'(power_cut));
    $display("test pin wake done");
    bus(1'b1, `HIB_OFS_IRQ_MASK, 32'h4);
    bus(1'b1, `HIB_OFS_IRQ_CLEAR, 32'hf);
    battery_low_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("bat_off", 32'(0), 32'(irq));
    rdc("raw_off", `HIB_OFS_IRQ_RAW, 32'h0);
    bus(1'b1, `HIB_OFS_CONTROL, 32'h60);
    repeat (3) @(posedge clk_sys);
    chk("bat_on", 32'(1), 32'(irq));
    rdc("raw_on", `HIB_OFS_IRQ_RAW, 32'h4);
    battery_low_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    bus(1'b1, `HIB_OFS_IRQ_CLEAR, 32'h4);
    @(posedge clk_sys);
    chk("bat_clr", 32'(0), 32'(irq));
    $display("test battery done");
    print_verdict();
  end
endmodule // hibernation_control_tb

`default_nettype wire
